// file: hdl/ecit_regs.svh
// register offsets, field positions, reset values and timing counts
`ifndef ECIT_REGS_SVH
`define ECIT_REGS_SVH

// ==========================================================
// register byte addresses
`define ECIT_ADDR_MODE 8'h00
`define ECIT_ADDR_FALL 8'h04
`define ECIT_ADDR_RISE 8'h08
`define ECIT_ADDR_CKSTOP 8'h0c
`define ECIT_ADDR_PORT 8'h10
`define ECIT_ADDR_IRQ 8'h14

// ==========================================================
// mode control fields
`define ECIT_MODE_OVERFLOW_HIGH_FLAG 7
`define ECIT_MODE_OVERFLOW_LOW_FLAG 6
`define ECIT_MODE_OVERFLOW_IRQ_ENABLE 5
`define ECIT_MODE_IEDGE 4
`define ECIT_MODE_CCLR_HI 3
`define ECIT_MODE_CCLR_LO 2
`define ECIT_MODE_CKS_HI 1
`define ECIT_MODE_CKS_LO 0
`define ECIT_MODE_RESET 8'h00

// ==========================================================
// other fields and reset values
`define ECIT_CKSTOP_TIMER 3
`define ECIT_CKSTOP_RESET 8'hff
`define ECIT_PORT_PIN_SEL 0
`define ECIT_PORT_NCS 1
`define ECIT_IRQ_FLAG 0
`define ECIT_IRQ_EN 1
`define ECIT_CNT_RESET 8'h00
`define ECIT_CNT_MAX 8'hff

// ==========================================================
// filter and dividers
`define ECIT_FILT_STAGES 5
`define ECIT_PRESC_W 6
`define ECIT_DIV64_BIT 5
`define ECIT_DIV32_BIT 4
`define ECIT_DIV2_BIT 0
`define ECIT_WDIV4_BIT 1

`endif

// file: hdl/ecit_pkg.sv
// types shared by the edge capture interval timer
package ecit_pkg;

    // ======================================================
    // count clock choice
    typedef enum logic [1:0] {
        ECIT_CKS_DIV64 = 2'h0,
        ECIT_CKS_DIV32 = 2'h1,
        ECIT_CKS_DIV2 = 2'h2,
        ECIT_CKS_WATCH4 = 2'h3
    } ecit_cks_t;

    // ======================================================
    // counter clear choice
    typedef enum logic [1:0] {
        ECIT_CLR_NEVER = 2'h0,
        ECIT_CLR_FALL = 2'h1,
        ECIT_CLR_RISE = 2'h2,
        ECIT_CLR_BOTH = 2'h3
    } ecit_clr_t;

    // ======================================================
    // bus responses
    typedef enum logic [1:0] {
        ECIT_RESP_OKAY = 2'h0,
        ECIT_RESP_DECERR = 2'h3
    } ecit_resp_t;

endpackage

// file: hdl/ecit_top.sv
// edge capture interval timer with axi4-lite register access
`timescale 1ns/1ps
`default_nettype none
`include "ecit_regs.svh"

module ecit_top (
    // clock and reset
    input wire logic i_clk_sys,
    input wire logic i_rst_n,
    // external pins
    input wire logic i_capture_pin,
    input wire logic i_watch_clk,
    // interrupt request
    output logic o_timer_irq,
    // axi4-lite write address
    input wire logic i_s_axi_awvalid,
    output logic o_s_axi_awready,
    input wire logic [7:0] i_s_axi_awaddr,
    // axi4-lite write data
    input wire logic i_s_axi_wvalid,
    output logic o_s_axi_wready,
    input wire logic [31:0] i_s_axi_wdata,
    input wire logic [3:0] i_s_axi_wstrb,
    // axi4-lite write response
    output logic o_s_axi_bvalid,
    input wire logic i_s_axi_bready,
    output ecit_pkg::ecit_resp_t o_s_axi_bresp,
    // axi4-lite read address
    input wire logic i_s_axi_arvalid,
    output logic o_s_axi_arready,
    input wire logic [7:0] i_s_axi_araddr,
    // axi4-lite read data
    output logic o_s_axi_rvalid,
    input wire logic i_s_axi_rready,
    output logic [31:0] o_s_axi_rdata,
    output ecit_pkg::ecit_resp_t o_s_axi_rresp
);
    import ecit_pkg::*;

    function automatic logic addr_mapped(input logic [7:0] a);
        addr_mapped = (a == `ECIT_ADDR_MODE) || (a == `ECIT_ADDR_FALL) ||
            (a == `ECIT_ADDR_RISE) || (a == `ECIT_ADDR_CKSTOP) ||
            (a == `ECIT_ADDR_PORT) || (a == `ECIT_ADDR_IRQ);
    endfunction

    // registers
    logic [5:0] mode_ctrl;
    logic overflow_high_flag;
    logic overflow_low_flag;
    logic overflow_high_flag_armed;
    logic overflow_low_flag_armed;
    logic [7:0] module_clock_stop;
    logic capture_pin_select;
    logic noise_filter_select;
    logic timer_irq_request_flag;
    logic timer_irq_enable;
    logic [7:0] capture_counter;
    logic [7:0] rise_capture_value;
    logic [7:0] fall_capture_value;

    // bus state
    logic aw_got;
    logic [7:0] aw_addr;
    logic w_got;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic aw_fire;
    logic w_fire;
    logic do_write;
    logic [7:0] wr_addr;
    logic [31:0] wr_data;
    logic wr_lane0;
    logic do_read;
    logic [31:0] rd_word;

    // timing
    logic [`ECIT_PRESC_W-1:0] presc;
    logic watch_s1;
    logic watch_s2;
    logic watch_prev;
    logic [1:0] watch_div;
    logic sel_level;
    logic prev_level;
    logic count_tick;
    logic sample_tick;
    logic timer_run;

    // capture path
    logic pin_s1;
    logic pin_s2;
    logic pin_gated;
    logic [`ECIT_FILT_STAGES-1:0] filt_sh;
    logic filt_out;
    logic filt_init;
    logic cap_sig;
    logic cap_prev;
    logic rise_edge;
    logic fall_edge;
    logic clr_hit;
    logic irq_edge;
    logic ovf_event;
    logic set_overflow_high_flag;
    logic set_overflow_low_flag;
    logic clr_overflow_high_flag;
    logic clr_overflow_low_flag;

    ecit_cks_t cks;
    ecit_clr_t cclr;

    assign cks = ecit_cks_t'(mode_ctrl[`ECIT_MODE_CKS_HI:`ECIT_MODE_CKS_LO]);
    assign cclr = ecit_clr_t'(mode_ctrl[`ECIT_MODE_CCLR_HI:`ECIT_MODE_CCLR_LO]);
    assign timer_run = module_clock_stop[`ECIT_CKSTOP_TIMER];

    // ======================================================
    // axi4-lite write channel
    assign o_s_axi_awready = !aw_got && !o_s_axi_bvalid;
    assign o_s_axi_wready = !w_got && !o_s_axi_bvalid;
    assign aw_fire = i_s_axi_awvalid && o_s_axi_awready;
    assign w_fire = i_s_axi_wvalid && o_s_axi_wready;
    assign do_write = (aw_got || aw_fire) && (w_got || w_fire);
    assign wr_addr = aw_got ? aw_addr : i_s_axi_awaddr;
    assign wr_data = w_got ? w_data : i_s_axi_wdata;
    assign wr_lane0 = do_write && (w_got ? w_strb[0] : i_s_axi_wstrb[0]);

    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            aw_got <= 1'b0;
            aw_addr <= 8'h00;
            w_got <= 1'b0;
            w_data <= 32'h0000_0000;
            w_strb <= 4'h0;
        end else if (do_write) begin
            aw_got <= 1'b0;
            w_got <= 1'b0;
        end else begin
            if (aw_fire) begin
                aw_got <= 1'b1;
                aw_addr <= i_s_axi_awaddr;
            end
            if (w_fire) begin
                w_got <= 1'b1;
                w_data <= i_s_axi_wdata;
                w_strb <= i_s_axi_wstrb;
            end
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_s_axi_bvalid <= 1'b0;
            o_s_axi_bresp <= ECIT_RESP_OKAY;
        end else if (do_write) begin
            o_s_axi_bvalid <= 1'b1;
            o_s_axi_bresp <= addr_mapped(wr_addr) ? ECIT_RESP_OKAY :
                ECIT_RESP_DECERR;
        end else if (i_s_axi_bready) begin
            o_s_axi_bvalid <= 1'b0;
        end
    end

    // ======================================================
    // axi4-lite read channel
    assign o_s_axi_arready = !o_s_axi_rvalid;
    assign do_read = i_s_axi_arvalid && o_s_axi_arready;

    always_comb begin
        rd_word = 32'h0000_0000;
        unique case (i_s_axi_araddr)
            `ECIT_ADDR_MODE: begin
                rd_word[7:0] = {overflow_high_flag, overflow_low_flag,
                    mode_ctrl};
            end
            `ECIT_ADDR_FALL: rd_word[7:0] = fall_capture_value;
            `ECIT_ADDR_RISE: rd_word[7:0] = rise_capture_value;
            `ECIT_ADDR_CKSTOP: rd_word[7:0] = module_clock_stop;
            `ECIT_ADDR_PORT: begin
                rd_word[`ECIT_PORT_PIN_SEL] = capture_pin_select;
                rd_word[`ECIT_PORT_NCS] = noise_filter_select;
            end
            `ECIT_ADDR_IRQ: begin
                rd_word[`ECIT_IRQ_FLAG] = timer_irq_request_flag;
                rd_word[`ECIT_IRQ_EN] = timer_irq_enable;
            end
            default: rd_word = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_s_axi_rvalid <= 1'b0;
            o_s_axi_rdata <= 32'h0000_0000;
            o_s_axi_rresp <= ECIT_RESP_OKAY;
        end else if (do_read) begin
            o_s_axi_rvalid <= 1'b1;
            o_s_axi_rdata <= rd_word;
            o_s_axi_rresp <= addr_mapped(i_s_axi_araddr) ? ECIT_RESP_OKAY :
                ECIT_RESP_DECERR;
        end else if (i_s_axi_rready) begin
            o_s_axi_rvalid <= 1'b0;
        end
    end

    // ======================================================
    // control registers
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            mode_ctrl <= 6'(`ECIT_MODE_RESET);
            module_clock_stop <= `ECIT_CKSTOP_RESET;
            capture_pin_select <= 1'b0;
            noise_filter_select <= 1'b0;
            timer_irq_enable <= 1'b0;
        end else if (wr_lane0) begin
            unique case (wr_addr)
                `ECIT_ADDR_MODE: mode_ctrl <= wr_data[5:0];
                `ECIT_ADDR_CKSTOP: module_clock_stop <= wr_data[7:0];
                `ECIT_ADDR_PORT: begin
                    capture_pin_select <= wr_data[`ECIT_PORT_PIN_SEL];
                    noise_filter_select <= wr_data[`ECIT_PORT_NCS];
                end
                `ECIT_ADDR_IRQ: timer_irq_enable <= wr_data[`ECIT_IRQ_EN];
                default: ;
            endcase
        end
    end

    // ======================================================
    // overflow flags: read as 1 arms, write 0 clears, set wins
    assign clr_overflow_high_flag = wr_lane0 && (wr_addr == `ECIT_ADDR_MODE) &&
        !wr_data[`ECIT_MODE_OVERFLOW_HIGH_FLAG] && overflow_high_flag_armed;
    assign clr_overflow_low_flag = wr_lane0 && (wr_addr == `ECIT_ADDR_MODE) &&
        !wr_data[`ECIT_MODE_OVERFLOW_LOW_FLAG] && overflow_low_flag_armed;

    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            overflow_high_flag <= 1'b0;
            overflow_high_flag_armed <= 1'b0;
        end else if (set_overflow_high_flag) begin
            overflow_high_flag <= 1'b1;
        end else if (clr_overflow_high_flag) begin
            overflow_high_flag <= 1'b0;
            overflow_high_flag_armed <= 1'b0;
        end else if (do_read && i_s_axi_araddr == `ECIT_ADDR_MODE &&
            overflow_high_flag) begin
            overflow_high_flag_armed <= 1'b1;
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            overflow_low_flag <= 1'b0;
            overflow_low_flag_armed <= 1'b0;
        end else if (set_overflow_low_flag) begin
            overflow_low_flag <= 1'b1;
        end else if (clr_overflow_low_flag) begin
            overflow_low_flag <= 1'b0;
            overflow_low_flag_armed <= 1'b0;
        end else if (do_read && i_s_axi_araddr == `ECIT_ADDR_MODE &&
            overflow_low_flag) begin
            overflow_low_flag_armed <= 1'b1;
        end
    end

    // ======================================================
    // timer irq flag: write 0 clears, set wins
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            timer_irq_request_flag <= 1'b0;
        end else if (irq_edge || (ovf_event && mode_ctrl[`ECIT_MODE_OVERFLOW_IRQ_ENABLE]))
        begin
            timer_irq_request_flag <= 1'b1;
        end else if (wr_lane0 && wr_addr == `ECIT_ADDR_IRQ &&
            !wr_data[`ECIT_IRQ_FLAG]) begin
            timer_irq_request_flag <= 1'b0;
        end
    end

    assign o_timer_irq = timer_irq_request_flag && timer_irq_enable;

    // ======================================================
    // count clock generation
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            presc <= '0;
        end else begin
            presc <= presc + 1'b1;
        end
    end

    // watch clock synchroniser and divide by four
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            watch_s1 <= 1'b0;
            watch_s2 <= 1'b0;
            watch_prev <= 1'b0;
            watch_div <= 2'h0;
        end else begin
            watch_s1 <= i_watch_clk;
            watch_s2 <= watch_s1;
            watch_prev <= watch_s2;
            if (watch_s2 && !watch_prev) begin
                watch_div <= watch_div + 2'h1;
            end
        end
    end

    always_comb begin
        unique case (cks)
            ECIT_CKS_DIV64: sel_level = presc[`ECIT_DIV64_BIT];
            ECIT_CKS_DIV32: sel_level = presc[`ECIT_DIV32_BIT];
            ECIT_CKS_DIV2: sel_level = presc[`ECIT_DIV2_BIT];
            ECIT_CKS_WATCH4: sel_level = watch_div[`ECIT_WDIV4_BIT];
        endcase
    end

    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            prev_level <= 1'b0;
        end else begin
            prev_level <= sel_level;
        end
    end

    // count on falling edge, sample filter on rising edge
    assign count_tick = timer_run && prev_level && !sel_level;
    assign sample_tick = timer_run && !prev_level && sel_level;

    // ======================================================
    // capture pin synchroniser and noise filter
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            pin_s1 <= 1'b0;
            pin_s2 <= 1'b0;
        end else begin
            pin_s1 <= i_capture_pin;
            pin_s2 <= pin_s1;
        end
    end

    // pin reads low when not selected as capture input
    assign pin_gated = pin_s2 && capture_pin_select;

    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            filt_sh <= '1;
            filt_out <= 1'b0;
            filt_init <= 1'b0;
        end else if (noise_filter_select ? sample_tick : timer_run) begin
            filt_sh <= {filt_sh[`ECIT_FILT_STAGES-2:0], pin_gated};
            if (filt_sh == '0) begin
                filt_out <= 1'b0;
                filt_init <= 1'b1;
            end else if (filt_sh == '1 && filt_init) begin
                filt_out <= 1'b1;
            end
        end
    end

    // switching the source may itself look like an edge
    assign cap_sig = noise_filter_select ? filt_out : pin_gated;

    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            cap_prev <= 1'b0;
        end else if (timer_run) begin
            cap_prev <= cap_sig;
        end
    end

    assign rise_edge = timer_run && capture_pin_select &&
        cap_sig && !cap_prev;
    assign fall_edge = timer_run && capture_pin_select &&
        !cap_sig && cap_prev;
    assign irq_edge = mode_ctrl[`ECIT_MODE_IEDGE] ? fall_edge :
        rise_edge;

    always_comb begin
        unique case (cclr)
            ECIT_CLR_NEVER: clr_hit = 1'b0;
            ECIT_CLR_FALL: clr_hit = fall_edge;
            ECIT_CLR_RISE: clr_hit = rise_edge;
            ECIT_CLR_BOTH: clr_hit = rise_edge || fall_edge;
        endcase
    end

    // ======================================================
    // counter, overflow and capture
    assign ovf_event = count_tick && !clr_hit &&
        capture_counter == `ECIT_CNT_MAX;
    assign set_overflow_high_flag = ovf_event && capture_pin_select && cap_sig;
    assign set_overflow_low_flag = ovf_event &&
        !(capture_pin_select && cap_sig);

    // counter has no bus access
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            capture_counter <= `ECIT_CNT_RESET;
        end else if (clr_hit) begin
            capture_counter <= `ECIT_CNT_RESET;
        end else if (count_tick) begin
            capture_counter <= capture_counter + 8'h01;
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rise_capture_value <= `ECIT_CNT_RESET;
            fall_capture_value <= `ECIT_CNT_RESET;
        end else begin
            if (rise_edge) begin
                rise_capture_value <= capture_counter;
            end
            if (fall_edge) begin
                fall_capture_value <= capture_counter;
            end
        end
    end

endmodule
`default_nettype wire

// file: tb/ecit_pulse_src.sv
// external pulse source driving the timer's capture pin
`timescale 1ns/1ps
`default_nettype none
module ecit_pulse_src (
    // clock
    input wire logic i_clk_sys,
    // capture pin
    output logic o_pin
);
    initial o_pin = 1'b0;
    // move the pin, then hold it for w clocks
    task automatic drive(input logic lvl, input int w);
        @(posedge i_clk_sys);
        o_pin <= lvl;
        repeat (w) @(posedge i_clk_sys);
    endtask
    task automatic pulse(input int w);
        drive(1'b1, w);
        drive(1'b0, w);
    endtask
endmodule
`default_nettype wire

// file: tb/ecit_top_monitor.sv
// bus and interrupt assertions on the timer's top ports
`timescale 1ns/1ps
`default_nettype none
module ecit_top_monitor (
    // clock and reset
    input wire logic i_clk_sys,
    input wire logic i_rst_n,
    // register bus
    input wire logic i_s_axi_awvalid,
    input wire logic o_s_axi_awready,
    input wire logic i_s_axi_wvalid,
    input wire logic o_s_axi_wready,
    input wire logic o_s_axi_bvalid,
    input wire logic i_s_axi_bready,
    input wire ecit_pkg::ecit_resp_t o_s_axi_bresp,
    input wire logic i_s_axi_arvalid,
    input wire logic o_s_axi_arready,
    input wire logic [7:0] i_s_axi_araddr,
    input wire logic o_s_axi_rvalid,
    input wire logic i_s_axi_rready,
    input wire logic [31:0] o_s_axi_rdata,
    input wire ecit_pkg::ecit_resp_t o_s_axi_rresp,
    // interrupt
    input wire logic o_timer_irq
);
    import ecit_pkg::*;
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_rst_n);
    // ==========================================================
    // write channel
    property p_b_hold;
        o_s_axi_bvalid && !i_s_axi_bready |=>
            o_s_axi_bvalid && $stable(o_s_axi_bresp);
    endproperty
    a_b_hold: assert property (p_b_hold)
        else $error("write response dropped early");
    property p_aw_block;
        o_s_axi_bvalid |-> !o_s_axi_awready && !o_s_axi_wready;
    endproperty
    a_aw_block: assert property (p_aw_block)
        else $error("write taken while response pending");
    property p_b_after;
        i_s_axi_awvalid && o_s_axi_awready && i_s_axi_wvalid &&
            o_s_axi_wready |=> o_s_axi_bvalid;
    endproperty
    a_b_after: assert property (p_b_after)
        else $error("write response late");
    // ==========================================================
    // read channel
    property p_r_hold;
        o_s_axi_rvalid && !i_s_axi_rready |=> o_s_axi_rvalid &&
            $stable(o_s_axi_rdata) && $stable(o_s_axi_rresp);
    endproperty
    a_r_hold: assert property (p_r_hold)
        else $error("read data dropped early");
    property p_ar_block;
        o_s_axi_rvalid |-> !o_s_axi_arready;
    endproperty
    a_ar_block: assert property (p_ar_block)
        else $error("read taken while data pending");
    property p_r_after;
        i_s_axi_arvalid && o_s_axi_arready |=> o_s_axi_rvalid;
    endproperty
    a_r_after: assert property (p_r_after)
        else $error("read data late");
    property p_unmapped;
        i_s_axi_arvalid && o_s_axi_arready && i_s_axi_araddr > 8'h14
            |=> o_s_axi_rresp == ECIT_RESP_DECERR && o_s_axi_rdata == 0;
    endproperty
    a_unmapped: assert property (p_unmapped)
        else $error("unmapped read not refused");
    property p_rd_upper;
        o_s_axi_rvalid |-> o_s_axi_rdata[31:8] == 24'h0;
    endproperty
    a_rd_upper: assert property (p_rd_upper)
        else $error("upper read bits not zero");
    // ==========================================================
    // interrupt drops only by a register write
    property p_irq_fall;
        $fell(o_timer_irq) |-> o_s_axi_bvalid || $past(o_s_axi_bvalid);
    endproperty
    a_irq_fall: assert property (p_irq_fall)
        else $error("interrupt fell without a write");
endmodule
bind ecit_top ecit_top_monitor ecit_top_monitor_i (.*);
`default_nettype wire

// file: tb/test_edge_capture_interval_timer.sv
// self-checking bench for the edge capture interval timer
`timescale 1ns/1ps
`default_nettype none
module test_edge_capture_interval_timer;
    import ecit_pkg::*;
    logic clk = 1'b0, rst_n = 1'b0, wclk = 1'b0, pin, irq;
    logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic [7:0] awaddr = 0, araddr = 0;
    logic [31:0] wdata = 0, rdata, v, v2;
    logic [3:0] wstrb = 0;
    logic awready, wready, bvalid, arready, rvalid;
    ecit_resp_t bresp, rresp;
    logic [65:0] q[$];
    logic [65:0] x;
    logic [7:0] ra[6] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14};
    logic [31:0] rv[6] = '{0, 0, 0, 32'hff, 0, 0};
    int sp[4] = '{4, 8, 128, 8};
    int failures = 0, checked = 0, i;
    always #10 clk = ~clk;
    always #80 wclk = ~wclk;
    ecit_pulse_src ecit_pulse_src_i (.i_clk_sys(clk), .o_pin(pin));
    ecit_top ecit_top_i (
        .i_clk_sys(clk), .i_rst_n(rst_n), .i_capture_pin(pin),
        .i_watch_clk(wclk), .o_timer_irq(irq),
        .i_s_axi_awvalid(awvalid), .o_s_axi_awready(awready),
        .i_s_axi_awaddr(awaddr), .i_s_axi_wvalid(wvalid),
        .o_s_axi_wready(wready), .i_s_axi_wdata(wdata),
        .i_s_axi_wstrb(wstrb), .o_s_axi_bvalid(bvalid),
        .i_s_axi_bready(bready), .o_s_axi_bresp(bresp),
        .i_s_axi_arvalid(arvalid), .o_s_axi_arready(arready),
        .i_s_axi_araddr(araddr), .o_s_axi_rvalid(rvalid),
        .i_s_axi_rready(rready), .o_s_axi_rdata(rdata),
        .o_s_axi_rresp(rresp));
    // ==========================================================
    // checking and closing
    task automatic chk(input string nm, input logic [33:0] s, e);
        checked++;
        if (s !== e) begin
            failures++;
            $display("unexpected %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic end_of_test;
        $display("checked %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    function automatic logic near(input logic [7:0] s, input int e);
        return s >= e - 1 && s <= e + 1;
    endfunction
    // ==========================================================
    // register bus master
    task automatic wr(input logic [7:0] a, d,
                      input ecit_resp_t r = ECIT_RESP_OKAY);
        int n;
        @(posedge clk);
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        awaddr <= a;
        wdata <= {24'h0, d};
        wstrb <= 4'hf;
        bready <= 1'b1;
        for (n = 0; !(bvalid && bready); n++) begin
            if (n == 100) begin
                failures++;
                end_of_test();
            end
            @(posedge clk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end
        chk("bresp", bresp, r);
        bready <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e, m,
                      output logic [31:0] o,
                      input ecit_resp_t r = ECIT_RESP_OKAY);
        int n;
        q.push_back({r, m, e});
        @(posedge clk);
        arvalid <= 1'b1;
        araddr <= a;
        rready <= 1'b1;
        for (n = 0; !(rvalid && rready); n++) begin
            if (n == 100) begin
                failures++;
                end_of_test();
            end
            @(posedge clk);
            if (arready) arvalid <= 1'b0;
        end
        o = rdata;
        rready <= 1'b0;
    endtask
    // read results against the oldest note
    always @(posedge clk) begin
        if (rvalid && rready && q.size() > 0) begin
            x = q.pop_front();
            chk("read", {rresp, rdata & x[63:32]}, {x[65:64], x[31:0]});
        end
    end
    // ==========================================================
    // scenarios
    initial begin
        void'($urandom(32'h7f1e));
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        foreach (ra[k]) rd(ra[k], rv[k], '1, v);
        rd(8'h18, 0, '1, v, ECIT_RESP_DECERR);
        wr(8'h18, 8'hff, ECIT_RESP_DECERR);
        // pulse width measured on each count clock
        wr(8'h10, 8'h01);
        for (i = 0; i < 4; i++) begin
            wr(8'h00, i[7:0]);
            ecit_pulse_src_i.pulse(256);
            rd(8'h08, 0, 0, v);
            rd(8'h04, 0, 0, v2);
            chk("span", near(v2[7:0] - v[7:0], sp[i]), 1);
        end
        // counter clearing on chosen edges
        for (i = 1; i < 4; i++) begin
            wr(8'h00, {4'h0, i[1:0], 2'h2});
            ecit_pulse_src_i.pulse(100);
            ecit_pulse_src_i.pulse(100);
            rd(8'h08, 0, 0, v);
            rd(8'h04, 0, 0, v2);
            if (i[1]) chk("fall clr", near(v2[7:0], 50), 1);
            if (i[0]) chk("rise clr", near(v[7:0], 50), 1);
        end
        // interrupt edge choice
        for (i = 0; i < 2; i++) begin
            wr(8'h00, {3'h0, i[0], 4'h2});
            wr(8'h14, 8'h02);
            ecit_pulse_src_i.drive(1'b1, 20);
            chk("irq rise", irq, !i[0]);
            ecit_pulse_src_i.drive(1'b0, 20);
            chk("irq fall", irq, 1);
        end
        // interval overflow, flag clearing
        wr(8'h10, 8'h00);
        // stale flags from capture runs: arm, then clear by the mode write
        rd(8'h00, 0, 0, v);
        wr(8'h00, 8'h22);
        wr(8'h14, 8'h02);
        repeat (600) @(posedge clk);
        chk("ovf irq", irq, 1);
        // hold the counter so no new overflow lands in the clear
        wr(8'h0c, 8'hf7);
        rd(8'h00, 32'h40, 32'h40, v);
        wr(8'h00, 8'h82);
        rd(8'h00, 0, 32'hc0, v);
        wr(8'h0c, 8'hff);
        // capture-mode overflow with the pin high
        wr(8'h10, 8'h01);
        ecit_pulse_src_i.drive(1'b1, 600);
        rd(8'h00, 32'h80, 32'h80, v);
        ecit_pulse_src_i.drive(1'b0, 20);
        // module standby
        wr(8'h0c, 8'hf7);
        wr(8'h14, 8'h02);
        ecit_pulse_src_i.pulse(20);
        chk("standby irq", irq, 0);
        wr(8'h0c, 8'hff);
        ecit_pulse_src_i.pulse(20);
        chk("run irq", irq, 1);
        // noise filter on the div2 count clock
        wr(8'h10, 8'h00);
        wr(8'h10, 8'h02);
        repeat (30) @(posedge clk);
        wr(8'h10, 8'h03);
        repeat (30) @(posedge clk);
        wr(8'h14, 8'h02);
        repeat (4) begin
            ecit_pulse_src_i.drive(1'b1, 1 + $urandom % 7);
            ecit_pulse_src_i.drive(1'b0, 20);
        end
        chk("noise irq", irq, 0);
        ecit_pulse_src_i.drive(1'b1, 6);
        chk("early irq", irq, 0);
        ecit_pulse_src_i.drive(1'b1, 30);
        chk("filtered irq", irq, 1);
        // pin held high: reselecting the pin alone looks like a rise
        wr(8'h10, 8'h00);
        wr(8'h14, 8'h02);
        chk("quiet irq", irq, 0);
        wr(8'h10, 8'h01);
        repeat (2) @(posedge clk);
        chk("false edge irq", irq, 1);
        end_of_test();
    end
endmodule
`default_nettype wire
